// ===== include/sar_cfg.svh
// timing counts, code limits, sample width and buffer depth of the conversion sequencer
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH
`define SAR_RES        13
`define SAR_MSB_IDX    4'hc
`define SAR_ACQ_FALLS  2'h2
`define SAR_NUM_CODES  14'h2000
`define SAR_CODE_MAX   13'h0fff
`define SAR_CODE_MIN   13'h1000
`define SAR_CODE_ONE   13'h0001
`define SAR_MAG_MAX    12'hfff
`define SAR_MAG_MIN    12'h000
`define SAR_SAMPLE_W   16
`define SAR_BUF_DEPTH  2
`endif

// ===== include/sar_pkg.sv
// types shared by the conversion sequencer
`include "sar_cfg.svh"
package sar_pkg;
  typedef enum logic [2:0] {
    SAR_IDLE = 3'b000,
    SAR_WAIT = 3'b001,
    SAR_ACQ  = 3'b010,
    SAR_CONV = 3'b011,
    SAR_DONE = 3'b100
  } sar_state_t;

  typedef struct packed {
    sar_state_t              st;
    logic [3:0]              idx;
    logic [1:0]              falls;
    logic [`SAR_RES-1:0]     held;
    logic [`SAR_RES-1:0]     approx;
    logic                    sdo;
    logic                    sdo_oe;
    logic                    standby;
    logic                    pop;
    logic                    sclk_s1;
    logic                    sclk_s2;
    logic                    sclk_s3;
    logic                    cs_s1;
    logic                    cs_s2;
  } sar_conv_t;
endpackage

// ===== rtl/sar_buf.sv
// two-entry sample buffer with valid and ready on both sides
`timescale 1ns/10ps
`include "sar_cfg.svh"
module sar_buf
  import sar_pkg::*;
#(
  parameter int W     = `SAR_SAMPLE_W,
  parameter int DEPTH = `SAR_BUF_DEPTH
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         rstn_i,
  // fill side
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  // drain side
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wptr;
    logic [PW-1:0]           rptr;
    logic [CW-1:0]           cnt;
    logic                    in_ready;
  } sar_buf_t;

  sar_buf_t q_r;
  sar_buf_t q_nxt;
  logic     push;
  logic     pop;

  assign push        = in_valid_i && q_r.in_ready;
  assign pop         = out_ready_i && (q_r.cnt != '0);
  assign in_ready_o  = q_r.in_ready;
  assign out_valid_o = (q_r.cnt != '0);
  assign out_data_o  = q_r.mem[q_r.rptr];

  always_comb begin
    q_nxt = q_r;
    if (push) begin
      q_nxt.mem[q_r.wptr] = in_data_i;
      q_nxt.wptr = (q_r.wptr == PW'(DEPTH - 1)) ? '0 : q_r.wptr + 1'b1;
    end
    if (pop) begin
      q_nxt.rptr = (q_r.rptr == PW'(DEPTH - 1)) ? '0 : q_r.rptr + 1'b1;
    end
    if (push && !pop) begin
      q_nxt.cnt = q_r.cnt + 1'b1;
    end else if (pop && !push) begin
      q_nxt.cnt = q_r.cnt - 1'b1;
    end
    q_nxt.in_ready = (q_nxt.cnt != CW'(DEPTH));
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_r          <= '0;
      q_r.in_ready <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule

// ===== rtl/sar_conv.sv
// conversion sequencer of the serial differential converter
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - sample window spans one and a half clocks
// - convert for thirteen clocks after sampling
// - one result bit per conversion clock
// - sign bit shifted out first
// - thirteen-bit twos complement from held charge
// - bipolar use spans all 8192 codes
// - limits are 0x1000 and 0x0fff
// - half lsb positive gives 0x0001
// - unipolar use equals twelve-bit resolution
// - any duty cycle and rate with each link clock level held for a system clock or more
// - select high aborts and enters standby
// - serial data changes on falling edges only while select is low; select high clears it
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`include "sar_cfg.svh"
module sar_conv
  import sar_pkg::*;
#(
  parameter int W = `SAR_SAMPLE_W
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         rstn_i,
  // serial link
  input  wire logic         select_shutdown_n_i,
  input  wire logic         sclk_i,
  output logic              sdo_o,
  output logic              sdo_oe_o,
  // quantised input difference
  input  wire logic [W-1:0] sample_data_i,
  input  wire logic         sample_valid_i,
  output logic              sample_ready_o,
  // status
  output logic              standby_o
);
  localparam sar_conv_t RST = '{
    st: SAR_IDLE, idx: 4'h0, falls: 2'h0, held: '0, approx: '0,
    sdo: 1'b0, sdo_oe: 1'b0, standby: 1'b1, pop: 1'b0,
    sclk_s1: 1'b0, sclk_s2: 1'b0, sclk_s3: 1'b0,
    cs_s1: 1'b1, cs_s2: 1'b1};
  localparam logic signed [W-1:0] LIM_HI = {{(W-12){1'b0}}, `SAR_MAG_MAX};
  localparam logic signed [W-1:0] LIM_LO = {{(W-12){1'b1}}, `SAR_MAG_MIN};

  sar_conv_t           q_r;
  sar_conv_t           q_nxt;
  logic [W-1:0]        buf_data;
  logic                buf_valid;
  logic                rise;
  logic                fall;
  logic                cs_low;
  logic [`SAR_RES-1:0] clamp_w;
  logic [`SAR_RES-1:0] src_w;
  logic [`SAR_RES-1:0] trial_w;
  logic                decide_w;

  //////////////////////////////////////////////////////////////////////////
  // sample buffer
  sar_buf #(
    .W     (W),
    .DEPTH (`SAR_BUF_DEPTH)
  ) u_buf (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .in_data_i   (sample_data_i),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (sample_ready_o),
    .out_data_o  (buf_data),
    .out_valid_o (buf_valid),
    .out_ready_i (q_r.pop)
  );

  //////////////////////////////////////////////////////////////////////////
  // edges of the synchronised link clock
  // edges found by sampling
  assign rise   = q_r.sclk_s2 && !q_r.sclk_s3;
  assign fall   = !q_r.sclk_s2 && q_r.sclk_s3;
  assign cs_low = !q_r.cs_s2;

  always_comb begin
    if ($signed(buf_data) > LIM_HI) begin
      clamp_w = `SAR_CODE_MAX;
    end else if ($signed(buf_data) < LIM_LO) begin
      clamp_w = `SAR_CODE_MIN;
    end else begin
      clamp_w = buf_data[`SAR_RES-1:0];
    end
  end

  always_comb begin
    if (q_r.st == SAR_ACQ) begin
      src_w = buf_valid ? (clamp_w ^ `SAR_CODE_MIN) : q_r.held;
      trial_w = `SAR_CODE_MIN;
    end else begin
      src_w = q_r.held;
      trial_w = q_r.approx | (`SAR_CODE_ONE << q_r.idx);
    end
    decide_w = (src_w >= trial_w);
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    q_nxt = q_r;
    q_nxt.sclk_s1 = sclk_i;
    q_nxt.sclk_s2 = q_r.sclk_s1;
    q_nxt.sclk_s3 = q_r.sclk_s2;
    q_nxt.cs_s1 = select_shutdown_n_i;
    q_nxt.cs_s2 = q_r.cs_s1;
    q_nxt.pop = 1'b0;
    if (!cs_low) begin
      q_nxt.st = SAR_IDLE;
      q_nxt.sdo = 1'b0;
      q_nxt.sdo_oe = 1'b0;
      q_nxt.standby = 1'b1;
    end else begin
      case (q_r.st)
        SAR_IDLE: begin
          q_nxt.st = SAR_WAIT;
          q_nxt.sdo = 1'b0;
          q_nxt.sdo_oe = 1'b1;
          q_nxt.standby = 1'b0;
        end
        SAR_WAIT: begin
          if (rise) begin
            q_nxt.st = SAR_ACQ;
            q_nxt.falls = 2'h0;
          end
        end
        SAR_ACQ: begin
          if (fall) begin
            q_nxt.falls = q_r.falls + 2'h1;
            if (q_r.falls == `SAR_ACQ_FALLS - 2'h1) begin
              q_nxt.st = SAR_CONV;
              q_nxt.held = src_w;
              q_nxt.pop = buf_valid;
              q_nxt.idx = `SAR_MSB_IDX - 4'h1;
              q_nxt.approx = decide_w ? trial_w : '0;
              q_nxt.sdo = !decide_w;
            end
          end
        end
        SAR_CONV: begin
          if (fall) begin
            q_nxt.sdo = decide_w;
            q_nxt.approx = decide_w ? trial_w : q_r.approx;
            q_nxt.idx = q_r.idx - 4'h1;
            if (q_r.idx == 4'h0) begin
              q_nxt.st = SAR_DONE;
            end
          end
        end
        SAR_DONE: begin
          if (fall) begin
            q_nxt.sdo = 1'b0;
          end
        end
        default: begin
          q_nxt.st = SAR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_r <= RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign sdo_o     = q_r.sdo;
  assign sdo_oe_o  = q_r.sdo_oe;
  assign standby_o = q_r.standby;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_hold_edge;
    q_r.st == SAR_ACQ && fall && cs_low && q_r.falls == 2'h1;
  endsequence
  sequence s_last_bit;
    q_r.st == SAR_CONV && fall && cs_low && q_r.idx == 4'h0;
  endsequence

  property p_acq;
    q_r.st == SAR_WAIT && rise && cs_low |=> q_r.st == SAR_ACQ;
  endproperty
  a_acq: assert property (p_acq) else $error("no sample window");
  property p_hold;
    s_hold_edge |=> q_r.st == SAR_CONV && q_r.idx == 4'hb;
  endproperty
  a_hold: assert property (p_hold) else $error("bad hold step");
  property p_done;
    s_last_bit |=> q_r.st == SAR_DONE;
  endproperty
  a_done: assert property (p_done) else $error("bit count wrong");
  property p_step;
    q_r.st == SAR_CONV && fall && cs_low && q_r.idx != 4'h0
      |=> q_r.st == SAR_CONV && q_r.idx == $past(q_r.idx) - 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("bit not resolved");
  property p_sign;
    s_hold_edge and buf_valid |=> q_r.sdo == $past(clamp_w[12]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign not first");
  property p_pop;
    s_hold_edge and buf_valid |=> q_r.pop ##1 !q_r.pop;
  endproperty
  a_pop: assert property (p_pop) else $error("sample not taken");
  property p_max;
    buf_valid && $signed(buf_data) > LIM_HI |-> clamp_w == `SAR_CODE_MAX;
  endproperty
  a_max: assert property (p_max) else $error("no high limit");
  property p_one;
    buf_valid && buf_data == W'(1) |-> clamp_w == `SAR_CODE_ONE;
  endproperty
  a_one: assert property (p_one) else $error("code one wrong");
  property p_abort;
    !cs_low |=> q_r.st == SAR_IDLE && !q_r.sdo_oe && q_r.standby;
  endproperty
  a_abort: assert property (p_abort) else $error("no standby");
  property p_fall_only;
    $changed(q_r.sdo) && q_r.st != SAR_IDLE && $past(cs_low)
      |-> $past(fall);
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("bad sdo");
endmodule

// ===== dv/sar_host.sv
// host controller model that frames conversions and reads the result
`timescale 1ns/10ps
module sar_host (
  // pacing clock
  input  wire logic clock_i,
  // serial link
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  input  wire logic standby_i,
  output logic      select_shutdown_n_o,
  output logic      sclk_o
);
  logic [12:0] code_r;
  logic        tail_r;
  logic        live_r;
  logic        steady_r;

  initial begin
    select_shutdown_n_o = 1'b1;
    sclk_o              = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // one frame: hi and lo in system clocks, ncyc link clocks
  task automatic frame(input int hi, input int lo, input int ncyc);
    logic bit_v;
    code_r   = 13'h0000;
    live_r   = 1'b1;
    steady_r = 1'b1;
    wait_clk(1);
    select_shutdown_n_o = 1'b0;
    wait_clk(6);
    // sample window and bit clocks, fast enough
    for (int c = 1; c <= ncyc; c++) begin
      bit_v = sdo_i;
      if (c >= 3 && c <= 15) code_r = {code_r[11:0], sdo_i};
      if (c == 16) tail_r = sdo_i;
      if (c >= 3 && (sdo_oe_i !== 1'b1 || standby_i !== 1'b0))
        live_r = 1'b0;
      sclk_o = 1'b1;
      wait_clk(hi);
      // no change while the clock is high
      if (sdo_i !== bit_v) steady_r = 1'b0;
      sclk_o = 1'b0;
      wait_clk(lo);
    end
    select_shutdown_n_o = 1'b1;
    wait_clk(8);
  endtask
endmodule

// ===== dv/tb_top.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/10ps
`include "sar_cfg.svh"
module tb_top;
  import sar_pkg::*;
  typedef struct packed {
    logic [15:0] word;
    logic [12:0] code;
  } sar_row_t;

  logic        clock_i;
  logic        rstn_i;
  logic        select_shutdown_n_i;
  logic        sclk_i;
  logic        sdo_o;
  logic        sdo_oe_o;
  logic        standby_o;
  logic        sample_valid_i;
  logic        sample_ready_o;
  logic [15:0] sample_data_i;
  int          fails;
  int          n_checks;
  sar_row_t    rows [10] = '{
    '{16'h0000, 13'h0000}, '{16'h0001, `SAR_CODE_ONE},
    '{16'hffff, 13'h1fff}, '{16'hfffe, 13'h1ffe},
    '{16'h0fff, `SAR_CODE_MAX}, '{16'h1000, `SAR_CODE_MAX},
    '{16'h7fff, `SAR_CODE_MAX}, '{16'hf000, `SAR_CODE_MIN},
    '{16'hefff, `SAR_CODE_MIN}, '{16'h0555, 13'h0555}};

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  sar_conv i_sar_conv (
    .clock_i             (clock_i),
    .rstn_i              (rstn_i),
    .select_shutdown_n_i (select_shutdown_n_i),
    .sclk_i              (sclk_i),
    .sdo_o               (sdo_o),
    .sdo_oe_o            (sdo_oe_o),
    .sample_data_i       (sample_data_i),
    .sample_valid_i      (sample_valid_i),
    .sample_ready_o      (sample_ready_o),
    .standby_o           (standby_o)
  );

  sar_host i_sar_host (
    .clock_i             (clock_i),
    .sdo_i               (sdo_o),
    .sdo_oe_i            (sdo_oe_o),
    .standby_i           (standby_o),
    .select_shutdown_n_o (select_shutdown_n_i),
    .sclk_o              (sclk_i)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic push(input logic [15:0] w);
    int k;
    k = 0;
    @(negedge clock_i);
    sample_data_i  = w;
    sample_valid_i = 1'b1;
    while (sample_ready_o !== 1'b1 && k < 200) begin
      @(negedge clock_i);
      k++;
    end
    @(negedge clock_i);
    sample_valid_i = 1'b0;
    sample_data_i  = ~w;
  endtask

  task automatic run(input int hi, input int lo, input logic [12:0] c);
    i_sar_host.frame(hi, lo, 16);
    chk("code", {3'h0, c}, {3'h0, i_sar_host.code_r});
    chk("tail", 16'h0000, {15'h0, i_sar_host.tail_r});
    chk("live", 16'h0001, {15'h0, i_sar_host.live_r});
    chk("steady", 16'h0001, {15'h0, i_sar_host.steady_r});
    chk("stby", 16'h0001, {15'h0, standby_o});
    chk("oe", 16'h0000, {15'h0, sdo_oe_o});
  endtask

  task automatic end_sim;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    fails++;
    end_sim();
  end

  initial begin
    rstn_i         = 1'b0;
    sample_valid_i = 1'b0;
    sample_data_i  = 16'h0000;
    repeat (3) @(negedge clock_i);
    chk("rst oe", 16'h0000, {15'h0, sdo_oe_o});
    chk("rst rdy", 16'h0001, {15'h0, sample_ready_o});
    rstn_i = 1'b1;
    foreach (rows[i]) begin
      push(rows[i].word);
      run(3, 5, rows[i].code);
    end
    // fill the buffer, a third word is refused
    push(16'h0123);
    push(16'hfedc);
    repeat (2) @(negedge clock_i);
    chk("full", 16'h0000, {15'h0, sample_ready_o});
    sample_data_i  = 16'h0777;
    sample_valid_i = 1'b1;
    repeat (4) @(negedge clock_i);
    sample_valid_i = 1'b0;
    run(3, 5, 13'h0123);
    run(6, 12, 13'h1edc);
    chk("empty", 16'h0001, {15'h0, sample_ready_o});
    run(3, 5, 13'h1edc);
    // abort a conversion part way
    push(16'h0042);
    i_sar_host.frame(3, 5, 5);
    chk("abort", 16'h0001, {15'h0, standby_o});
    chk("abort oe", 16'h0000, {15'h0, sdo_oe_o});
    // reset in mid-run with a full buffer empties it
    push(16'h0333);
    push(16'h0444);
    @(negedge clock_i);
    chk("full2", 16'h0000, {15'h0, sample_ready_o});
    rstn_i = 1'b0;
    @(negedge clock_i);
    chk("rst2 rdy", 16'h0001, {15'h0, sample_ready_o});
    chk("rst2 stby", 16'h0001, {15'h0, standby_o});
    chk("rst2 oe", 16'h0000, {15'h0, sdo_oe_o});
    repeat (2) @(negedge clock_i);
    rstn_i = 1'b1;
    push(16'h0fff);
    run(3, 5, 13'h0fff);
    end_sim();
  end
endmodule
